// >>> pkg/pwr_pkg.sv
// Package with register map, field positions, reset values and states of the power-down control.
package pwr_pkg;
  // Index of the power configuration register and its byte address on the bus.
  localparam logic [11:0] PWR_CFG_IDX = 12'h087;
  localparam logic [11:0] PWR_CFG_ADDR = 12'(PWR_CFG_IDX * 4);
  // Wake enable register index and byte address.
  localparam logic [11:0] WAKE_EN_IDX = 12'h088;
  localparam logic [11:0] WAKE_EN_ADDR = 12'(WAKE_EN_IDX * 4);
  // Status register index and byte address.
  localparam logic [11:0] STATUS_IDX = 12'h089;
  localparam logic [11:0] STATUS_ADDR = 12'(STATUS_IDX * 4);
  // Field positions in the power configuration register.
  localparam int IDLE_BIT = 0;
  localparam int PDREQ_BIT = 1;
  localparam int FLAG0_BIT = 2;
  localparam int FLAG1_BIT = 3;
  // Field positions in the wake enable register.
  localparam int WEN_A_BIT = 0;
  localparam int WEN_B_BIT = 1;
  // Reset values.
  localparam logic [3:0] PWR_CFG_RST = 4'h0;
  localparam logic [1:0] WAKE_EN_RST = 2'h0;
  // Number of synchronised pin inputs: wake line a, wake line b, reset pin.
  localparam int SYNC_W = 3;
  // Operating states of the core power control.
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_IDLE = 3'b001,
    ST_PDOWN = 3'b010,
    ST_WAKE_HOLD = 3'b011,
    ST_RST_WIN = 3'b100
  } pwr_state_e;
  // AHB transfer type for a non-sequential transfer.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage : pwr_pkg

// >>> pkg/sync_if.sv
// Interface that carries raw pin levels to the synchroniser and synchronised levels back.
`timescale 1ns/1ps
interface sync_if #(parameter int W = 3);
  logic [W-1:0] raw; // Raw pin levels from outside the clock domain.
  logic [W-1:0] synced; // Levels after two flip-flops.
  // Side that owns the pins and uses the result.
  modport user (output raw, input synced);
  // Side that performs the synchronisation.
  modport syncer (input raw, output synced);
endinterface : sync_if

// >>> rtl/pin_sync.sv
// Two flip-flop synchroniser bank for asynchronous pin inputs.
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Pin levels in, synchronised levels out.
  sync_if.syncer sif
);
  logic [W-1:0] meta_ff; // First stage, read only by the second stage.
  logic [W-1:0] sync_ff; // Second stage, safe for logic.

  // Each bit passes two flip-flops before any logic sees it.
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          meta_ff[g] <= RST_VAL[g];
          sync_ff[g] <= RST_VAL[g];
        end else begin
          meta_ff[g] <= sif.raw[g];
          sync_ff[g] <= meta_ff[g];
        end
      end
    end
  endgenerate

  assign sif.synced = sync_ff;
endmodule : pin_sync

// >>> rtl/power_down_wake_control.sv
// Power-down and wake control with pin state control and an AHB-Lite register slave.
//
// Register access over AHB-Lite and the address map were decided locally.
`timescale 1ns/1ps

// How it works
// - Enter power-down right after request write.
// - Request write is last; core halts until wake.
// - Only the two external lines wake.
// - Enabled wake clears request, restarts clocks.
// - Hold execution until waking line released.
// - Service routine first, then following instruction.
// - Interrupt wake leaves registers and RAM alone.
// - Reset pin clears request asynchronously, restarts clocks.
// - Brief execution, then reset fetches from zero.
// - Brief window blocks RAM, allows port access; here pins keep reset levels while reset pin is high.
// - Reset wake reloads registers, keeps RAM.
// - Reset: port 0 floats, rest drive high.
// - Idle: ports hold, strobes high, port 0 varies.
// - Power-down: ports hold, strobes low, port 0 varies.
// - Request bit is bit one of configuration.
// - Idle and power-down together give power-down.
// - Power-down stops oscillator, freezes clocks, keeps state.
module power_down_wake_control (
  // Clock and synchronous reset from the internal reset sequencer.
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Reset pin, active high, asynchronous.
  input wire logic i_rst_pin,
  // External wake interrupt pins, active low.
  input wire logic i_ext_wake_irq_a_n,
  input wire logic i_ext_wake_irq_b_n,
  // Any enabled core interrupt, used only to leave idle.
  input wire logic i_core_irq,
  // Core pin requests and code location.
  input wire logic i_ext_code,
  input wire logic [7:0] i_port0_out,
  input wire logic i_port0_oe,
  input wire logic [31:0] i_port14_out,
  input wire logic i_ale,
  input wire logic i_program_store_strobe_n,
  // AHB-Lite slave.
  input wire logic i_hsel,
  input wire logic [11:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  // Clock and core control.
  output logic o_osc_en,
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_cpu_halt,
  output logic o_wake_isr_req,
  output logic o_wake_isr_src,
  output logic o_ram_block,
  // Pins.
  output logic [7:0] o_port0_out,
  output logic o_port0_oe,
  output logic [31:0] o_port14_out,
  output logic o_ale,
  output logic o_program_store_strobe_n
);
  import pwr_pkg::*;

  // Synchronised pins.
  sync_if #(.W(SYNC_W)) sif ();
  logic irq_a_n_s; // Wake line a after synchronisation.
  logic irq_b_n_s; // Wake line b after synchronisation.
  logic rst_pin_s; // Reset pin after synchronisation.

  // Registers.
  logic powerdown_request_bit_ff; // Power-down request, cleared asynchronously by the pin.
  logic idle_request_bit_ff; // Idle request.
  logic [1:0] gen_flag_ff; // General purpose flags.
  logic [1:0] wake_en_ff; // Wake enable per external line.
  pwr_state_e state_ff; // Operating state.
  pwr_state_e nxt_state; // Next operating state.
  logic wake_src_ff; // Line that caused the last wake, 1 for line b.

  // Bus address phase capture.
  logic wr_pend_ff; // A write data phase is in progress.
  logic [11:0] wr_addr_ff; // Address of the pending write.

  // Output flops.
  logic [31:0] hrdata_ff;
  logic osc_en_ff;
  logic cpu_clk_en_ff;
  logic periph_clk_en_ff;
  logic cpu_halt_ff;
  logic isr_req_ff;
  logic ram_block_ff;
  logic [7:0] port0_ff;
  logic port0_oe_ff;
  logic [31:0] port14_ff;
  logic ale_ff;
  logic prog_strobe_n_ff;

  // The pin synchroniser releases the reset pin as inactive and the wake lines as idle high.
  assign sif.raw = {i_rst_pin, i_ext_wake_irq_b_n, i_ext_wake_irq_a_n};
  pin_sync #(.W(SYNC_W), .RST_VAL(3'b011)) u_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .sif(sif)
  );
  assign irq_a_n_s = sif.synced[0];
  assign irq_b_n_s = sif.synced[1];
  assign rst_pin_s = sif.synced[2];

  // Bus decode: a write lands in the data phase that follows its address phase.
  wire addr_phase = i_hsel & i_hready & (i_htrans == HTRANS_NONSEQ);
  wire cfg_wr = wr_pend_ff & (wr_addr_ff == PWR_CFG_ADDR);
  wire wen_wr = wr_pend_ff & (wr_addr_ff == WAKE_EN_ADDR);
  wire pdreq_write_one = cfg_wr & i_hwdata[PDREQ_BIT];
  wire idle_write_one = cfg_wr & i_hwdata[IDLE_BIT];

  // Only the two external lines, when enabled, count as wake causes.
  wire wake_a = wake_en_ff[WEN_A_BIT] & ~irq_a_n_s;
  wire wake_b = wake_en_ff[WEN_B_BIT] & ~irq_b_n_s;
  wire wake_any = wake_a | wake_b;
  wire waking_line_n = wake_src_ff ? irq_b_n_s : irq_a_n_s;

  // Values the registers take this edge, so a read right after a write returns new data.
  wire nxt_pdreq = (state_ff == ST_PDOWN && wake_any) ? 1'b0 :
                   (cfg_wr ? i_hwdata[PDREQ_BIT] : powerdown_request_bit_ff);
  wire nxt_idle = (state_ff == ST_IDLE && i_core_irq) ? 1'b0 :
                  (cfg_wr ? i_hwdata[IDLE_BIT] : idle_request_bit_ff);
  wire [1:0] nxt_gf = cfg_wr ? i_hwdata[FLAG1_BIT:FLAG0_BIT] : gen_flag_ff;
  wire [1:0] nxt_wen = wen_wr ? i_hwdata[1:0] : wake_en_ff;
  wire [31:0] rd_pwr_cfg = {28'h0, nxt_gf, nxt_pdreq, nxt_idle};
  wire [31:0] rd_wen = {30'h0, nxt_wen};
  wire [31:0] rd_status = {24'h0, rst_pin_s, irq_b_n_s, irq_a_n_s, wake_src_ff,
                           1'b0, state_ff};
  wire [31:0] nxt_hrdata = (i_haddr == PWR_CFG_ADDR) ? rd_pwr_cfg :
                           (i_haddr == WAKE_EN_ADDR) ? rd_wen :
                           (i_haddr == STATUS_ADDR) ? rd_status : 32'h0;
  wire rd_take = addr_phase & ~i_hwrite;

  // Next state of the power control.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        // Power-down wins over idle when both are written together.
        if (pdreq_write_one) begin
          nxt_state = ST_PDOWN;
        end else if (idle_write_one) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        // Idle ends on any core interrupt or a reset pin.
        if (rst_pin_s) begin
          nxt_state = ST_RST_WIN;
        end else if (i_core_irq) begin
          nxt_state = ST_RUN;
        end
      end
      ST_PDOWN: begin
        // The reset pin has already cleared the request; execution runs until reset takes over.
        if (rst_pin_s) begin
          nxt_state = ST_RST_WIN;
        end else if (wake_any) begin
          nxt_state = ST_WAKE_HOLD;
        end
      end
      ST_WAKE_HOLD: begin
        // Clocks run, but the core waits for the waking line to be released.
        if (rst_pin_s) begin
          nxt_state = ST_RST_WIN;
        end else if (waking_line_n) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RST_WIN: begin
        // Stays until the internal reset resets this block.
        nxt_state = ST_RST_WIN;
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // Request bit with direct asynchronous clear from the reset pin.
  always_ff @(posedge i_clk or posedge i_rst_pin) begin
    if (i_rst_pin) begin
      powerdown_request_bit_ff <= 1'b0;
    end else if (!i_rst_n) begin
      powerdown_request_bit_ff <= PWR_CFG_RST[PDREQ_BIT];
    end else begin
      powerdown_request_bit_ff <= nxt_pdreq;
    end
  end

  // Oscillator enable also restarts at once when the reset pin goes high.
  always_ff @(posedge i_clk or posedge i_rst_pin) begin
    if (i_rst_pin) begin
      osc_en_ff <= 1'b1;
    end else if (!i_rst_n) begin
      osc_en_ff <= 1'b1;
    end else begin
      osc_en_ff <= (nxt_state != ST_PDOWN);
    end
  end

  // Software registers; internal reset reloads them, interrupt wake leaves them as they are.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      idle_request_bit_ff <= PWR_CFG_RST[IDLE_BIT];
      gen_flag_ff <= PWR_CFG_RST[FLAG1_BIT:FLAG0_BIT];
      wake_en_ff <= WAKE_EN_RST;
    end else begin
      idle_request_bit_ff <= nxt_idle;
      gen_flag_ff <= nxt_gf;
      wake_en_ff <= nxt_wen;
    end
  end

  // State and wake source.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_ff <= ST_RUN;
      wake_src_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == ST_PDOWN && wake_any) begin
        wake_src_ff <= ~wake_a;
      end
    end
  end

  // Bus capture and read data; the slave never waits and always answers OKAY.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 12'h000;
      hrdata_ff <= 32'h0;
    end else begin
      wr_pend_ff <= addr_phase & i_hwrite;
      wr_addr_ff <= i_haddr;
      if (rd_take) begin
        hrdata_ff <= nxt_hrdata;
      end
    end
  end

  // Clock enables, halt, service request and RAM block.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cpu_clk_en_ff <= 1'b1;
      periph_clk_en_ff <= 1'b1;
      cpu_halt_ff <= 1'b0;
      isr_req_ff <= 1'b0;
      ram_block_ff <= 1'b0;
    end else begin
      cpu_clk_en_ff <= (nxt_state != ST_PDOWN) && (nxt_state != ST_IDLE);
      periph_clk_en_ff <= (nxt_state != ST_PDOWN);
      cpu_halt_ff <= (nxt_state != ST_RUN) && (nxt_state != ST_RST_WIN);
      isr_req_ff <= (state_ff == ST_WAKE_HOLD) && (nxt_state == ST_RUN);
      ram_block_ff <= (nxt_state == ST_RST_WIN);
    end
  end

  // Pin states: reset, idle, power-down, or the core's own values.
  wire pin_reset = ~i_rst_n | rst_pin_s;
  wire held = (state_ff == ST_IDLE) || (state_ff == ST_PDOWN);
  wire strobe_hi = (state_ff == ST_IDLE);
  always_ff @(posedge i_clk) begin
    if (pin_reset) begin
      port0_oe_ff <= 1'b0;
      port14_ff <= 32'hFFFFFFFF;
      ale_ff <= 1'b1;
      prog_strobe_n_ff <= 1'b1;
      port0_ff <= 8'h00;
    end else if (held) begin
      port0_oe_ff <= ~i_ext_code & port0_oe_ff;
      ale_ff <= strobe_hi;
      prog_strobe_n_ff <= strobe_hi;
    end else begin
      port0_ff <= i_port0_out;
      port0_oe_ff <= i_port0_oe;
      port14_ff <= i_port14_out;
      ale_ff <= i_ale;
      prog_strobe_n_ff <= i_program_store_strobe_n;
    end
  end

  assign o_hrdata = hrdata_ff;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_osc_en = osc_en_ff;
  assign o_cpu_clk_en = cpu_clk_en_ff;
  assign o_periph_clk_en = periph_clk_en_ff;
  assign o_cpu_halt = cpu_halt_ff;
  assign o_wake_isr_req = isr_req_ff;
  assign o_wake_isr_src = wake_src_ff;
  assign o_ram_block = ram_block_ff;
  assign o_port0_out = port0_ff;
  assign o_port0_oe = port0_oe_ff;
  assign o_port14_out = port14_ff;
  assign o_ale = ale_ff;
  assign o_program_store_strobe_n = prog_strobe_n_ff;

  // Checks, all on the one clock and idle during internal reset.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n || i_rst_pin);

  a_entry_halts_core: assert property (
    (state_ff == ST_RUN && pdreq_write_one && !rst_pin_s) |=>
      (state_ff == ST_PDOWN && o_cpu_halt))
    else $error("Power-down not entered after request write.");

  a_halt_held_down: assert property (
    (state_ff == ST_PDOWN) |-> (o_cpu_halt && !o_cpu_clk_en && !o_osc_en))
    else $error("Core or clocks running in power-down.");

  a_no_other_wake: assert property (
    (state_ff == ST_PDOWN && !wake_any && !rst_pin_s) |=> (state_ff == ST_PDOWN))
    else $error("Power-down left without an enabled external wake.");

  a_wake_clears_req: assert property (
    (state_ff == ST_PDOWN && wake_any && !rst_pin_s) |=>
      (!powerdown_request_bit_ff && o_osc_en && o_periph_clk_en))
    else $error("Wake did not clear request and restart clocks.");

  a_hold_until_rel: assert property (
    (state_ff == ST_WAKE_HOLD && !waking_line_n && !rst_pin_s) |=> o_cpu_halt)
    else $error("Execution resumed while wake line still held.");

  a_isr_after_rel: assert property (
    (state_ff == ST_WAKE_HOLD && waking_line_n && !rst_pin_s) |=>
      (o_wake_isr_req && !o_cpu_halt) ##1 !o_wake_isr_req)
    else $error("Service request not a single pulse on release.");

  a_ram_block_win: assert property (
    (state_ff == ST_RST_WIN) |-> (o_ram_block && !o_cpu_halt))
    else $error("RAM not blocked in reset wake window.");

  a_down_strobes_low: assert property (
    (state_ff == ST_PDOWN && $past(state_ff) == ST_PDOWN && !rst_pin_s) |=>
      (!o_ale && !o_program_store_strobe_n && $stable(o_port14_out)))
    else $error("Strobes not low or ports not held in power-down.");

  a_idle_strobes_hi: assert property (
    (state_ff == ST_IDLE && !rst_pin_s) |=> (o_ale && o_program_store_strobe_n))
    else $error("Strobes not high in idle.");

  a_pins_in_reset: assert property (
    rst_pin_s |=> (!o_port0_oe && o_port14_out == 32'hFFFFFFFF && o_ale))
    else $error("Pins not in reset state.");
endmodule : power_down_wake_control

// >>> verification/power_down_wake_control_tb.sv
// Self-checking testbench of the power-down and wake control.
`timescale 1ns/1ps
module power_down_wake_control_tb;
  import pwr_pkg::*;
  // Inputs driven by the bench.
  logic i_clk, i_rst_n, i_core_irq, i_ext_code, i_port0_oe, i_ale, i_program_store_strobe_n;
  logic i_hsel, i_hwrite, i_hready;
  logic [7:0] i_port0_out;
  logic [31:0] i_port14_out, i_hwdata;
  logic [11:0] i_haddr;
  logic [1:0] i_htrans;
  logic [2:0] i_hsize;
  // Lines from the source model.
  logic line_a_n, line_b_n, rst_pin;
  // Design outputs.
  logic [31:0] o_hrdata, o_port14_out;
  logic [7:0] o_port0_out;
  logic o_hreadyout, o_hresp, o_osc_en, o_cpu_clk_en, o_periph_clk_en, o_cpu_halt;
  logic o_wake_isr_req, o_wake_isr_src, o_ram_block, o_port0_oe, o_ale, o_program_store_strobe_n;
  // Bus answer as seen at the rising edge, and bench state.
  logic s_rdy;
  logic [31:0] s_rdata, rd, held;
  logic [7:0] p0;
  int n_mismatch = 0;
  int cmp_count = 0;

  power_down_wake_control power_down_wake_control_inst (
    .i_clk, .i_rst_n, .i_rst_pin(rst_pin), .i_ext_wake_irq_a_n(line_a_n),
    .i_ext_wake_irq_b_n(line_b_n), .i_core_irq, .i_ext_code, .i_port0_out, .i_port0_oe,
    .i_port14_out, .i_ale, .i_program_store_strobe_n, .i_hsel, .i_haddr, .i_htrans,
    .i_hwrite, .i_hsize, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp,
    .o_osc_en, .o_cpu_clk_en, .o_periph_clk_en, .o_cpu_halt, .o_wake_isr_req,
    .o_wake_isr_src, .o_ram_block, .o_port0_out, .o_port0_oe, .o_port14_out, .o_ale,
    .o_program_store_strobe_n
  );
  wake_source_model wake_source_model_inst (
    .i_clk, .o_line_a_n(line_a_n), .o_line_b_n(line_b_n), .o_rst_pin(rst_pin)
  );

  // Clock of 25 ns period.
  always #12.5 i_clk = ~i_clk;
  // Capture the bus answer at the edge so reads never race the design.
  always @(posedge i_clk) begin
    s_rdy <= o_hreadyout;
    s_rdata <= o_hrdata;
  end

  // Step to just after the next rising edge.
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask : tick
  // Compare a result, four-state exact.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Print the counts and the verdict, then stop.
  task automatic finish_test();
    $display("comparisons=%0d mismatches=%0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test
  // One single AHB-Lite transfer; read data lands in rd.
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    i_hsel <= 1'b1;
    i_haddr <= a;
    i_hwrite <= wr;
    i_htrans <= HTRANS_NONSEQ;
    for (int ph = 0; ph < 2; ph++) begin
      n = 0;
      do begin
        tick();
        n++;
      end while (s_rdy !== 1'b1 && n < 20);
      if (s_rdy !== 1'b1) begin
        n_mismatch++;
        finish_test();
      end
      // Data phase starts only once the address phase has been taken.
      if (ph == 0) begin
        i_htrans <= 2'h0;
        i_hwdata <= wd;
      end
    end
    rd = s_rdata;
  endtask : bus
  // Pick an output to wait on.
  function automatic logic pick(input int s);
    case (s)
      0: pick = o_osc_en;
      1: pick = o_cpu_halt;
      2: pick = o_wake_isr_req;
      3: pick = o_ram_block;
      default: pick = o_cpu_clk_en;
    endcase
  endfunction : pick
  // Bounded wait for an output level; running out ends the run.
  task automatic wait_on(input int s, input logic v);
    int n;
    n = 0;
    while (pick(s) !== v && n < 20) begin
      tick();
      n++;
    end
    if (pick(s) !== v) begin
      n_mismatch++;
      finish_test();
    end
  endtask : wait_on
  // Expected configuration word: both flags, request and idle bits.
  function automatic logic [31:0] cfg(input logic gf, input logic pd, input logic idle_request_bit);
    cfg = {28'h0, gf, gf, pd, idle_request_bit};
  endfunction : cfg

  // Watchdog against a hang anywhere.
  initial begin
    repeat (5000) @(posedge i_clk);
    n_mismatch++;
    finish_test();
  end

  // Main sequence.
  initial begin
    void'($urandom(60));
    {i_clk, i_rst_n, i_core_irq, i_ext_code, i_hsel, i_hwrite} = 6'h00;
    {i_port0_oe, i_ale, i_program_store_strobe_n, i_hready} = 4'hF;
    {i_haddr, i_htrans, i_hwdata} = '0;
    i_hsize = 3'h2;
    i_port0_out = 8'($urandom);
    i_port14_out = $urandom;
    repeat (2) tick();
    chk(o_port0_oe, 32'h0);
    chk(o_port14_out, 32'hFFFFFFFF);
    chk({o_ale, o_program_store_strobe_n}, 32'h3);
    i_rst_n <= 1'b1;
    tick();
    bus(1'b0, PWR_CFG_ADDR, 32'h0);
    chk(rd, 32'h0);
    chk({o_hresp, o_hreadyout}, 32'h1);
    bus(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    // Idle with external code: strobes high, ports held, port 0 floats.
    {i_ext_code, i_ale, i_program_store_strobe_n} <= 3'h4;
    i_port14_out <= $urandom;
    tick();
    held = i_port14_out;
    bus(1'b1, PWR_CFG_ADDR, cfg(1'b1, 1'b0, 1'b1));
    wait_on(4, 1'b0);
    chk({o_osc_en, o_periph_clk_en}, 32'h3);
    // Pins switch to their idle levels one edge after the state does.
    tick();
    chk({o_ale, o_program_store_strobe_n, o_port0_oe}, 32'h6);
    i_port14_out <= ~held;
    tick();
    chk(o_port14_out, held);
    i_core_irq <= 1'b1;
    wait_on(4, 1'b1);
    i_core_irq <= 1'b0;
    // Power-down, woken by each line in turn; line b also sets idle.
    for (int s = 0; s < 2; s++) begin
      bus(1'b1, WAKE_EN_ADDR, 32'(1 << s));
      i_ext_code <= s[0];
      {i_ale, i_program_store_strobe_n} <= 2'h3;
      i_port0_out <= 8'($urandom);
      i_port14_out <= $urandom;
      tick();
      {held, p0} = {i_port14_out, i_port0_out};
      bus(1'b1, PWR_CFG_ADDR, cfg(1'b1, 1'b1, s[0]));
      wait_on(1, 1'b1);
      chk({o_osc_en, o_cpu_clk_en, o_periph_clk_en}, 32'h0);
      repeat (2) tick();
      chk({o_ale, o_program_store_strobe_n}, 32'h0);
      {i_port14_out, i_port0_out, i_core_irq} <= {~held, ~p0, 1'b1};
      wake_source_model_inst.line_low(s == 0);
      repeat (6) tick();
      chk({o_cpu_halt, o_osc_en}, 32'h2);
      chk(o_port14_out, held);
      chk(o_port0_oe, 32'(s == 0));
      if (s == 0) begin
        chk(o_port0_out, 32'(p0));
      end
      i_core_irq <= 1'b0;
      wake_source_model_inst.line_release();
      wake_source_model_inst.line_low(s[0]);
      wait_on(0, 1'b1);
      chk({o_cpu_halt, o_cpu_clk_en, o_periph_clk_en}, 32'h7);
      bus(1'b0, PWR_CFG_ADDR, 32'h0);
      chk(rd & 32'hE, 32'hC);
      wake_source_model_inst.line_release();
      wait_on(2, 1'b1);
      chk({o_cpu_halt, o_wake_isr_src}, 32'(s));
      tick();
      chk(o_wake_isr_req, 32'h0);
      bus(1'b0, WAKE_EN_ADDR, 32'h0);
      chk(rd, 32'(1 << s));
    end
    // Power-down left through the reset pin.
    // The core's port inputs stay untouched after this request.
    bus(1'b1, PWR_CFG_ADDR, cfg(1'b1, 1'b1, 1'b0));
    wait_on(1, 1'b1);
    fork
      wake_source_model_inst.pin_reset(8);
    join_none
    @(negedge i_clk);
    #2;
    chk(o_osc_en, 32'h1);
    tick();
    wait_on(3, 1'b1);
    chk(o_cpu_halt, 32'h0);
    repeat (3) tick();
    chk({o_port0_oe, o_ale, o_program_store_strobe_n}, 32'h3);
    chk(o_port14_out, 32'hFFFFFFFF);
    bus(1'b0, PWR_CFG_ADDR, 32'h0);
    chk(rd & 32'h2, 32'h0);
    i_rst_n <= 1'b0;
    repeat (2) tick();
    i_rst_n <= 1'b1;
    tick();
    chk(o_ram_block, 32'h0);
    bus(1'b0, PWR_CFG_ADDR, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, WAKE_EN_ADDR, 32'h0);
    chk(rd, 32'h0);
    finish_test();
  end
endmodule : power_down_wake_control_tb

// >>> verification/wake_source_model.sv
// Model of the external wake sources and the reset pin driver.
`timescale 1ns/1ps
module wake_source_model #(
  parameter int SETTLE = 6
) (
  // Clock.
  input wire logic i_clk,
  // Wake lines, active low, and reset pin, active high.
  output logic o_line_a_n,
  output logic o_line_b_n,
  output logic o_rst_pin
);
  int low_cnt; // Cycles for which a wake line has been low.
  // Lines idle released and the reset pin low.
  initial begin
    o_line_a_n = 1'b1;
    o_line_b_n = 1'b1;
    o_rst_pin = 1'b0;
    low_cnt = 0;
  end
  // Count low time, so a release never comes before the oscillator settles.
  always @(posedge i_clk) begin
    low_cnt <= (o_line_a_n && o_line_b_n) ? 0 : low_cnt + 1;
  end
  // Pull one wake line low just after an edge; the level wakes, not an edge.
  task automatic line_low(input logic sel);
    @(posedge i_clk);
    if (sel) begin
      o_line_b_n <= 1'b0;
    end else begin
      o_line_a_n <= 1'b0;
    end
  endtask : line_low
  // Release both lines once the settle time has run out.
  task automatic line_release();
    @(posedge i_clk);
    while (low_cnt < SETTLE) @(posedge i_clk);
    o_line_a_n <= 1'b1;
    o_line_b_n <= 1'b1;
  endtask : line_release
  // Raise the reset pin between edges, since it acts without the clock.
  task automatic pin_reset(input int n);
    @(negedge i_clk);
    o_rst_pin = 1'b1;
    repeat (n) @(posedge i_clk);
    o_rst_pin <= 1'b0;
  endtask : pin_reset
endmodule : wake_source_model
